// >>> core/stsq_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - Secure mode protects data and teach-in alike
// - 24-bit explicit counter, 3-byte code, no cipher
// - Inner payload equals standard-mode payload unchanged
// - Secure teach-in precedes profile teach; secure data can go out before any teach-in
// - Secure teach-in carries format, key, counter
// - Learn press in secure mode: secure teach, then profile teach; standard mode: profile teach only
// - Profile teach after secure teach is protected
// - Standard cycle: three sub-telegrams within 40 ms
// - Random gaps between sub-telegram bursts
// - Standard sub-telegram lasts about 1.2 ms
// - Secure cycle: two sub-telegrams within 20 ms
// - Secure sub-telegram lasts about 1.6 ms
// - Counter steps once per secure telegram
// - Only selected counter values go to flash
// - Counter kept in retained memory over sleep
// - Three-byte save fast, page erase 40 ms
// - Any wake input change starts the module
// - Learn button low: teach-in or mode change
module stsq_sequencer #(parameter int TICK_CYCLES = stsq_pkg::TICK_CYCLES) (
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    input  wire logic                        i_general_wake_input,
    input  wire logic                        i_learn_wake_input,
    input  wire logic                        i_secure_mode,
    input  wire logic                        i_mode_change_sel,
    input  wire logic                        i_data_req,
    input  wire logic [stsq_pkg::PAY_W-1:0]  i_payload,
    input  wire logic [stsq_pkg::PAY_W-1:0]  i_teach_payload,
    input  wire logic [stsq_pkg::KEY_W-1:0]  i_key,
    input  wire logic                        i_restore,
    input  wire logic [stsq_pkg::CNT_W-1:0]  i_restore_counter,
    output logic                             o_wakeup,
    output logic                             o_mode_change,
    output logic                             o_busy,
    output logic                             o_radio_on,
    output logic                             o_sub_start,
    output stsq_pkg::stsq_tel_s              o_tel,
    output logic      [stsq_pkg::CNT_W-1:0]  o_retained_counter,
    output logic                             o_flash_write,
    output logic      [stsq_pkg::CNT_W-1:0]  o_flash_data,
    output logic                             o_flash_erase
);
    localparam int TW = stsq_pkg::TMR_W;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_BUILD = 5'h02,
        ST_SEND  = 5'h04,
        ST_GAP   = 5'h08,
        ST_ERASE = 5'h10
    } stsq_state_e;

    stsq_state_e                  state_reg;
    stsq_pkg::stsq_kind_e         kind_reg;
    logic                         sec_reg;
    logic                         chain_reg;
    logic [TW-1:0]                tmr_reg;
    logic [1:0]                   subs_reg;
    logic [stsq_pkg::PAY_W-1:0]   pay_reg;
    logic [stsq_pkg::CNT_W-1:0]   counter_reg;
    logic [stsq_pkg::CNT_W-1:0]   ctr_use;
    logic [7:0]                   slot_reg;
    logic                         erase_pend_reg;
    logic                         start_reg;
    logic                         gw_reg;
    logic                         lw_reg;
    logic                         press;
    logic                         tick;
    logic [stsq_pkg::DIV_W-1:0]   div_reg;
    logic                         mac_valid;
    logic [stsq_pkg::MAC_W-1:0]   mac;
    logic [15:0]                  rnd;
    logic                         commit;
    logic                         sub_end;

    function automatic logic [TW-1:0] sub_ticks(input logic sec);
        return sec ? stsq_pkg::SUB_SEC_TK : stsq_pkg::SUB_STD_TK;
    endfunction

    function automatic logic [TW-1:0] win_ticks(input logic sec);
        return sec ? stsq_pkg::WIN_SEC_TK : stsq_pkg::WIN_STD_TK;
    endfunction

    assign press   = lw_reg & ~i_learn_wake_input;
    assign ctr_use = sec_reg ? counter_reg + 24'h000001 : counter_reg;
    assign commit  = (state_reg == ST_BUILD) && mac_valid;
    assign sub_end = (state_reg == ST_SEND) && tick && (tmr_reg == '0);

    // ==========================================
    // Submodules
    // ==========================================
    stsq_mac u_mac (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_start   (start_reg),
        .i_key     (i_key),
        .i_payload (pay_reg),
        .i_counter (ctr_use),
        .o_valid   (mac_valid),
        .o_mac     (mac)
    );

    stsq_lfsr #(.W(16)) u_lfsr (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .o_value  (rnd)
    );

    // ==========================================
    // Wake detection
    // ==========================================
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            gw_reg   <= 1'b1;
            lw_reg   <= 1'b1;
            o_wakeup <= 1'b0;
        end else begin
            gw_reg   <= i_general_wake_input;
            lw_reg   <= i_learn_wake_input;
            o_wakeup <= (gw_reg ^ i_general_wake_input) | (lw_reg ^ i_learn_wake_input);
        end
    end

    // ==========================================
    // Tick divider
    // ==========================================
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            div_reg <= '0;
            tick    <= 1'b0;
        end else begin
            tick <= (div_reg == stsq_pkg::DIV_W'(TICK_CYCLES - 1));
            if (div_reg == stsq_pkg::DIV_W'(TICK_CYCLES - 1)) begin
                div_reg <= '0;
            end else begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end

    // ==========================================
    // Sequencer
    // ==========================================
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_reg     <= ST_IDLE;
            kind_reg      <= stsq_pkg::KIND_DATA;
            sec_reg       <= 1'b0;
            chain_reg     <= 1'b0;
            tmr_reg       <= '0;
            subs_reg      <= '0;
            pay_reg       <= '0;
            start_reg     <= 1'b0;
            o_mode_change <= 1'b0;
            o_busy        <= 1'b0;
            o_radio_on    <= 1'b0;
            o_sub_start   <= 1'b0;
            o_flash_erase <= 1'b0;
        end else begin
            start_reg     <= 1'b0;
            o_mode_change <= 1'b0;
            o_sub_start   <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (erase_pend_reg) begin
                        state_reg     <= ST_ERASE;
                        tmr_reg       <= stsq_pkg::ERASE_TK - 1'b1;
                        o_flash_erase <= 1'b1;
                        o_busy        <= 1'b1;
                    end else if (press && i_mode_change_sel) begin
                        o_mode_change <= 1'b1;
                    end else if (press) begin
                        sec_reg   <= i_secure_mode;
                        chain_reg <= i_secure_mode;
                        kind_reg  <= i_secure_mode ? stsq_pkg::KIND_SECTEACH
                                                   : stsq_pkg::KIND_PROFILE;
                        pay_reg   <= i_secure_mode ? '0 : i_teach_payload;
                        start_reg <= 1'b1;
                        state_reg <= ST_BUILD;
                        o_busy    <= 1'b1;
                    end else if (i_data_req) begin
                        sec_reg   <= i_secure_mode;
                        kind_reg  <= stsq_pkg::KIND_DATA;
                        pay_reg   <= i_payload;
                        start_reg <= 1'b1;
                        state_reg <= ST_BUILD;
                        o_busy    <= 1'b1;
                    end
                end
                ST_BUILD: begin
                    if (mac_valid) begin
                        state_reg   <= ST_SEND;
                        tmr_reg     <= sub_ticks(sec_reg) - 1'b1;
                        subs_reg    <= (sec_reg ? stsq_pkg::SUBS_SEC
                                                : stsq_pkg::SUBS_STD) - 2'h1;
                        o_radio_on  <= 1'b1;
                        o_sub_start <= 1'b1;
                    end
                end
                ST_SEND: begin
                    if (tick) begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end
                    if (sub_end) begin
                        o_radio_on <= 1'b0;
                        if (subs_reg != 2'h0) begin
                            state_reg <= ST_GAP;
                            tmr_reg   <= {{(TW - stsq_pkg::GAP_BITS){1'b0}},
                                          rnd[stsq_pkg::GAP_BITS-1:0]};
                        end else if (chain_reg) begin
                            chain_reg <= 1'b0;
                            kind_reg  <= stsq_pkg::KIND_PROFILE;
                            pay_reg   <= i_teach_payload;
                            start_reg <= 1'b1;
                            state_reg <= ST_BUILD;
                        end else begin
                            state_reg <= ST_IDLE;
                            o_busy    <= 1'b0;
                        end
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        tmr_reg <= tmr_reg - 1'b1;
                        if (tmr_reg == '0) begin
                            state_reg   <= ST_SEND;
                            tmr_reg     <= sub_ticks(sec_reg) - 1'b1;
                            subs_reg    <= subs_reg - 2'h1;
                            o_radio_on  <= 1'b1;
                            o_sub_start <= 1'b1;
                        end
                    end
                end
                ST_ERASE: begin
                    if (tick) begin
                        tmr_reg <= tmr_reg - 1'b1;
                        if (tmr_reg == '0) begin
                            state_reg     <= ST_IDLE;
                            o_flash_erase <= 1'b0;
                            o_busy        <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_reg  <= ST_IDLE;
                    o_busy     <= 1'b0;
                    o_radio_on <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // Rolling counter and flash saves
    // ==========================================
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            counter_reg        <= stsq_pkg::CNT_INIT;
            o_retained_counter <= stsq_pkg::CNT_INIT;
            slot_reg           <= '0;
            erase_pend_reg     <= 1'b0;
            o_flash_write      <= 1'b0;
            o_flash_data       <= '0;
        end else begin
            o_flash_write <= 1'b0;
            if (state_reg == ST_ERASE) begin
                erase_pend_reg <= 1'b0;
            end
            if (commit && sec_reg) begin
                counter_reg        <= ctr_use;
                o_retained_counter <= ctr_use;
                if ((ctr_use & stsq_pkg::SAVE_MASK) == '0) begin
                    o_flash_write <= 1'b1;
                    o_flash_data  <= ctr_use;
                    if (slot_reg == 8'(stsq_pkg::PAGE_SLOTS - 1)) begin
                        slot_reg       <= '0;
                        erase_pend_reg <= 1'b1;
                    end else begin
                        slot_reg <= slot_reg + 8'h01;
                    end
                end
            end else if (i_restore && state_reg == ST_IDLE) begin
                counter_reg        <= i_restore_counter;
                o_retained_counter <= i_restore_counter;
            end
        end
    end

    // ==========================================
    // Telegram output
    // ==========================================
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_tel <= '0;
        end else if (commit) begin
            o_tel.kind    <= kind_reg;
            o_tel.secure  <= sec_reg;
            o_tel.security_level_format     <= sec_reg ? stsq_pkg::SLF_DEFAULT : 8'h00;
            o_tel.payload <= pay_reg;
            o_tel.counter <= sec_reg ? ctr_use : '0;
            o_tel.mac     <= sec_reg ? mac : '0;
            o_tel.key     <= (kind_reg == stsq_pkg::KIND_SECTEACH) ? i_key : '0;
        end
    end

    // ==========================================
    // Assertions
    // ==========================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    logic [TW-1:0] on_tk;
    logic [TW-1:0] win_tk;
    logic [1:0]    sent;
    always_ff @(posedge i_clk) begin
        if (!i_resetn || state_reg == ST_IDLE) begin
            on_tk  <= '0;
            win_tk <= '0;
            sent   <= '0;
        end else begin
            if (o_sub_start) begin
                on_tk <= TW'(tick);
                sent  <= sent + 2'h1;
            end else if (tick && o_radio_on) begin
                on_tk <= on_tk + 1'b1;
            end
            if (state_reg == ST_BUILD) begin
                win_tk <= '0;
                sent   <= '0;
            end else if (tick) begin
                win_tk <= win_tk + 1'b1;
            end
        end
    end

    sub_length_a: assert property ($fell(o_radio_on) |-> on_tk == sub_ticks(sec_reg))
        else $error("Sub-telegram length wrong");
    window_a: assert property (o_sub_start |-> win_tk <= win_ticks(sec_reg))
        else $error("Sub-telegram outside window");
    sub_count_a: assert property (sub_end && !chain_reg && subs_reg == 2'h0
        |-> sent == (sec_reg ? stsq_pkg::SUBS_SEC : stsq_pkg::SUBS_STD))
        else $error("Wrong sub-telegram count");
    teach_chain_a: assert property (sub_end && subs_reg == 2'h0 && chain_reg
        |=> state_reg == ST_BUILD && kind_reg == stsq_pkg::KIND_PROFILE)
        else $error("Profile teach not chained");
    ctr_step_a: assert property (commit && sec_reg |=> counter_reg == $past(counter_reg) + 1'b1)
        else $error("Counter did not step");
    ctr_hold_a: assert property (commit && !sec_reg |=> $stable(counter_reg))
        else $error("Counter moved in standard mode");
    protect_a: assert property (o_sub_start && sec_reg |-> o_tel.secure && o_tel.security_level_format == stsq_pkg::SLF_DEFAULT)
        else $error("Secure telegram unprotected");
    payload_same_a: assert property (o_sub_start |-> o_tel.payload == pay_reg)
        else $error("Payload altered");
    teach_key_a: assert property (o_sub_start && o_tel.kind == stsq_pkg::KIND_SECTEACH
        |-> o_tel.key == i_key && o_tel.counter == counter_reg)
        else $error("Secure teach-in content wrong");
    wake_a: assert property ($changed(i_general_wake_input) || $changed(i_learn_wake_input)
        |=> o_wakeup)
        else $error("Wake change missed");
    flash_sel_a: assert property (o_flash_write |-> (o_flash_data & stsq_pkg::SAVE_MASK) == '0
        && o_flash_data == counter_reg)
        else $error("Unselected counter saved");

    teach_cov: cover property (sub_end && chain_reg ##1 state_reg == ST_BUILD);
    data_cov: cover property (o_sub_start && o_tel.kind == stsq_pkg::KIND_DATA && !sec_reg);
    erase_cov: cover property ($fell(o_flash_erase));
endmodule

// >>> common/stsq_pkg.sv
package stsq_pkg;

    // ==========================================
    // Clock and time base
    // ==========================================
    localparam int CLK_MHZ     = 100;
    localparam int TICK_US     = 10;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int DIV_W       = 10;

    // ==========================================
    // Transmit timing
    // ==========================================
    localparam int SUB_STD_US = 1200;
    localparam int SUB_SEC_US = 1600;
    localparam int WIN_STD_MS = 40;
    localparam int WIN_SEC_MS = 20;
    localparam int ERASE_MS   = 40;
    localparam int TMR_W      = 16;

    localparam logic [TMR_W-1:0] SUB_STD_TK = TMR_W'(SUB_STD_US / TICK_US);
    localparam logic [TMR_W-1:0] SUB_SEC_TK = TMR_W'(SUB_SEC_US / TICK_US);
    localparam logic [TMR_W-1:0] WIN_STD_TK = TMR_W'(WIN_STD_MS * 1000 / TICK_US);
    localparam logic [TMR_W-1:0] WIN_SEC_TK = TMR_W'(WIN_SEC_MS * 1000 / TICK_US);
    localparam logic [TMR_W-1:0] ERASE_TK   = TMR_W'(ERASE_MS * 1000 / TICK_US);

    localparam logic [1:0] SUBS_STD = 2'h3;
    localparam logic [1:0] SUBS_SEC = 2'h2;
    localparam int         GAP_BITS = 10;

    // ==========================================
    // Security format
    // ==========================================
    localparam int CNT_W = 24;
    localparam int MAC_W = 3 * 8;
    localparam int KEY_W = 128;
    localparam int PAY_W = 32;

    localparam logic [CNT_W-1:0] CNT_INIT    = 24'h000000;
    localparam logic [7:0]       SLF_DEFAULT = 8'h00;
    localparam logic [CNT_W-1:0] SAVE_MASK   = 24'h00000F;
    localparam int               PAGE_SLOTS  = 16;

    typedef enum logic [1:0] {
        KIND_DATA     = 2'h0,
        KIND_PROFILE  = 2'h1,
        KIND_SECTEACH = 2'h2
    } stsq_kind_e;

    typedef struct packed {
        stsq_kind_e         kind;
        logic               secure;
        logic [7:0]         security_level_format;
        logic [PAY_W-1:0]   payload;
        logic [CNT_W-1:0]   counter;
        logic [MAC_W-1:0]   mac;
        logic [KEY_W-1:0]   key;
    } stsq_tel_s;

endpackage

// >>> core/stsq_lfsr.sv
`timescale 1ns/1ps
module stsq_lfsr #(
    parameter int          W    = 16,
    parameter logic [15:0] SEED = 16'hACE1
) (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    output logic      [W-1:0] o_value
);
    // ==========================================
    // Free running pseudo random source
    // ==========================================
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_value <= W'(SEED);
        end else begin
            o_value <= {o_value[W-2:0], o_value[W-1] ^ o_value[W-3] ^ o_value[W-4] ^ o_value[W-6]};
        end
    end
endmodule

// >>> core/stsq_mac.sv
`timescale 1ns/1ps
module stsq_mac (
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    input  wire logic                        i_start,
    input  wire logic [stsq_pkg::KEY_W-1:0]  i_key,
    input  wire logic [stsq_pkg::PAY_W-1:0]  i_payload,
    input  wire logic [stsq_pkg::CNT_W-1:0]  i_counter,
    output logic                             o_valid,
    output logic      [stsq_pkg::MAC_W-1:0]  o_mac
);
    // ==========================================
    // Keyed code over counter and payload
    // ==========================================
    function automatic logic [stsq_pkg::MAC_W-1:0] fold(
        input logic [stsq_pkg::KEY_W-1:0] key,
        input logic [stsq_pkg::PAY_W-1:0] pay,
        input logic [stsq_pkg::CNT_W-1:0] cnt
    );
        logic [stsq_pkg::MAC_W-1:0] acc;
        acc = cnt ^ pay[23:0] ^ {16'h0000, pay[31:24]} ^ {16'h0000, key[127:120]};
        for (int i = 0; i < 5; i++) begin
            acc = {acc[22:0], acc[23]} ^ key[i*24 +: 24];
        end
        return acc;
    endfunction

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_valid <= 1'b0;
            o_mac   <= '0;
        end else begin
            o_valid <= i_start;
            if (i_start) begin
                o_mac <= fold(i_key, i_payload, i_counter);
            end
        end
    end
endmodule

// >>> test/stsq_rx_model.sv
`timescale 1ns/1ps
// ==========================================
// Receiver that learns the security profile
// ==========================================
module stsq_rx_model (
    input  wire logic                      i_clk,
    input  wire logic                      i_resetn,
    input  wire logic                      i_sub_start,
    input  wire stsq_pkg::stsq_tel_s       i_tel,
    output logic                           o_learned,
    output logic [7:0]                     o_refused,
    output logic [stsq_pkg::KEY_W-1:0]     o_key
);
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_learned <= 1'b0;
            o_refused <= 8'h00;
            o_key     <= '0;
        end else if (i_sub_start && i_tel.kind == stsq_pkg::KIND_SECTEACH) begin
            o_learned <= 1'b1;
            o_key     <= i_tel.key;
        end else if (i_sub_start && i_tel.secure && !o_learned) begin
            o_refused <= o_refused + 8'h01;
        end
    end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
    logic                  i_clk, i_resetn, i_general_wake_input, i_learn_wake_input;
    logic                  i_secure_mode, i_mode_change_sel, i_data_req, i_restore;
    logic [31:0]           i_payload, i_teach_payload;
    logic [127:0]          i_key;
    logic [23:0]           i_restore_counter, o_retained_counter, o_flash_data, fdat;
    logic                  o_wakeup, o_mode_change, o_busy, o_radio_on, o_sub_start;
    logic                  o_flash_write, o_flash_erase, rx_learned, flw;
    logic [7:0]            rx_refused;
    logic [127:0]          rx_key;
    stsq_pkg::stsq_tel_s   o_tel;
    stsq_pkg::stsq_tel_s   tl [8];
    int                    st [8], en [8];
    int                    n_sub, cyc, failures, n_tests, k, n;
    localparam int TC = 10;
    stsq_sequencer #(.TICK_CYCLES(TC)) stsq_sequencer_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_general_wake_input(i_general_wake_input), .i_learn_wake_input(i_learn_wake_input),
        .i_secure_mode(i_secure_mode), .i_mode_change_sel(i_mode_change_sel),
        .i_data_req(i_data_req), .i_payload(i_payload), .i_teach_payload(i_teach_payload),
        .i_key(i_key), .i_restore(i_restore), .i_restore_counter(i_restore_counter),
        .o_wakeup(o_wakeup), .o_mode_change(o_mode_change), .o_busy(o_busy),
        .o_radio_on(o_radio_on), .o_sub_start(o_sub_start), .o_tel(o_tel),
        .o_retained_counter(o_retained_counter), .o_flash_write(o_flash_write),
        .o_flash_data(o_flash_data), .o_flash_erase(o_flash_erase));
    stsq_rx_model stsq_rx_model_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_sub_start(o_sub_start), .i_tel(o_tel), .o_learned(rx_learned),
        .o_refused(rx_refused), .o_key(rx_key));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) cyc <= cyc + 1;
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic wrap_up();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic watch();
        int t;
        n_sub = 0;
        flw = 1'b0;
        t = 0;
        while (t < 5 || o_busy === 1'b1) begin
            @(posedge i_clk);
            #1;
            t++;
            if (o_sub_start === 1'b1 && n_sub < 8) begin
                tl[n_sub] = o_tel;
                st[n_sub] = cyc;
                n_sub++;
            end
            if (o_radio_on === 1'b1 && n_sub > 0) en[n_sub-1] = cyc;
            if (o_flash_write === 1'b1) begin
                flw = 1'b1;
                fdat = o_flash_data;
            end
            if (t > 40000) begin
                chk("timeout", 32'h0, 32'h1);
                wrap_up();
            end
        end
    endtask
    task automatic chk_tel(input int i0, input int m, input logic [1:0] kd, input logic sc,
        input logic [31:0] pl, input logic [23:0] ct, input int sub_tk, input int win_tk);
        int ln;
        chk("kind", 32'(kd), 32'(tl[i0].kind));
        chk("secure", 32'(sc), 32'(tl[i0].secure));
        chk("payload", pl, tl[i0].payload);
        chk("counter", 32'(ct), 32'(tl[i0].counter));
        chk("window", 32'h1, 32'(en[i0+m-1] - st[i0] < win_tk * TC));
        for (int i = 0; i < m; i++) begin
            ln = en[i0+i] - st[i0+i] + 1;
            chk("sub_len", 32'h1, 32'(ln >= (sub_tk - 1) * TC && ln <= (sub_tk + 1) * TC));
            chk("same_sub", 32'h1, 32'(tl[i0+i] === tl[i0]));
        end
    endtask
    task automatic pulse_req(input logic sec);
        @(posedge i_clk);
        i_secure_mode <= sec;
        i_data_req    <= 1'b1;
        @(posedge i_clk);
        i_data_req    <= 1'b0;
        watch();
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_wake();
        for (int e = 0; e < 2; e++) begin
            @(posedge i_clk);
            i_general_wake_input <= logic'(e);
            n = 0;
            repeat (4) begin
                @(posedge i_clk);
                #1;
                if (o_wakeup === 1'b1) n++;
            end
            chk("wakeup", 32'h1, 32'(n));
        end
        $display("test wake done");
    endtask
    task automatic t_mode();
        @(posedge i_clk);
        i_mode_change_sel  <= 1'b1;
        i_learn_wake_input <= 1'b0;
        n = 0;
        k = 0;
        repeat (10) begin
            @(posedge i_clk);
            #1;
            if (o_mode_change === 1'b1) n++;
            if (o_busy !== 1'b0) k++;
        end
        chk("mode_change", 32'h1, 32'(n));
        chk("busy_cycles", 32'h0, 32'(k));
        i_learn_wake_input <= 1'b1;
        i_mode_change_sel  <= 1'b0;
        repeat (4) @(posedge i_clk);
        $display("test mode done");
    endtask
    task automatic t_std();
        pulse_req(1'b0);
        chk("std_subs", 32'h3, 32'(n_sub));
        chk_tel(0, 3, 2'h0, 1'b0, i_payload, 24'h000000, 120, 4000);
        chk("std_mac", 32'h0, 32'(tl[0].mac));
        chk("gaps", 32'h1, 32'((st[1] - en[0]) != (st[2] - en[1])));
        $display("test std done");
    endtask
    task automatic t_teach();
        @(posedge i_clk);
        i_secure_mode      <= 1'b1;
        i_learn_wake_input <= 1'b0;
        watch();
        i_learn_wake_input <= 1'b1;
        chk("teach_subs", 32'h4, 32'(n_sub));
        chk_tel(0, 2, 2'h2, 1'b1, 32'h00000000, 24'h000001, 160, 2000);
        chk_tel(2, 2, 2'h1, 1'b1, i_teach_payload, 24'h000002, 160, 2000);
        chk("slf", 32'(stsq_pkg::SLF_DEFAULT), 32'(tl[0].security_level_format));
        chk("teach_key", 32'h1, 32'(tl[0].key === i_key));
        chk("rx_key", 32'h1, 32'(rx_key === i_key));
        chk("rx_learned", 32'h1, 32'(rx_learned));
        chk("rx_refused", 32'h0, 32'(rx_refused));
        $display("test teach done");
    endtask
    task automatic t_flash();
        @(posedge i_clk);
        i_restore_counter <= 24'h00000F;
        i_restore         <= 1'b1;
        @(posedge i_clk);
        i_restore         <= 1'b0;
        repeat (3) @(posedge i_clk);
        pulse_req(1'b1);
        chk_tel(0, 2, 2'h0, 1'b1, i_payload, 24'h000010, 160, 2000);
        chk("flash_write", 32'h1, 32'(flw));
        chk("flash_data", 32'h00000010, 32'(fdat));
        chk("retained", 32'h00000010, 32'(o_retained_counter));
        $display("test flash done");
    endtask
    initial begin
        {i_general_wake_input, i_learn_wake_input} = 2'h3;
        {i_secure_mode, i_mode_change_sel, i_data_req, i_restore} = 4'h0;
        i_payload = 32'hA5C30F12;
        i_teach_payload = 32'h5A3CF081;
        i_key = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
        i_restore_counter = 24'h000000;
        i_resetn = 1'b0;
        {cyc, failures, n_tests} = '0;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        #1;
        chk("reset_busy", 32'h0, 32'({o_busy, o_radio_on, o_flash_erase}));
        chk("reset_counter", 32'h0, 32'(o_retained_counter));
        t_wake();
        t_mode();
        t_std();
        t_teach();
        t_flash();
        wrap_up();
    end
endmodule
